// [design/afc_cfg.svh]
// Purpose: Named constants for the strobe controller of an external FIFO.
// Assumes: 40 MHz system clock, 25 ns period.
// Notes: Times are in ns; cycle counts are derived from them.
`ifndef AFC_CFG_SVH
`define AFC_CFG_SVH
`define AFC_CLK_NS 25
`define AFC_DEPTH 2048
`define AFC_WIDTH 9
`define AFC_PULSE_NS 80
`define AFC_RECOV_NS 20
`define AFC_SETUP_NS 40
`define AFC_ACCESS_NS 80
`define AFC_FLAG_NS 100
`define AFC_SYNC_CYC 3
`define AFC_PULSE_CYC ((`AFC_PULSE_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_RECOV_CYC ((`AFC_RECOV_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_SETUP_CYC ((`AFC_SETUP_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_ACCESS_CYC ((`AFC_ACCESS_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_FLAG_CYC ((`AFC_FLAG_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_FIFO_DEPTH 8
`define AFC_CNT_W 4
`endif

// [design/afc_fifo.sv]
// Purpose: Small staging FIFO for words bound for the external FIFO.
// Assumes: Same clock both sides; read data from a register.
// Notes: Full is exact; valid lags a write by one cycle; pop only when out valid.
`timescale 1ns/10ps
`default_nettype none
module afc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic i_sys_clk, // System clock
  input wire logic i_reset, // Synchronous reset, high
  input wire logic i_in_valid, // Word offered
  input wire logic [WIDTH-1:0] i_in_data, // Word to store
  output logic o_in_ready, // Room for a word
  output logic o_out_valid, // Head word valid
  output logic [WIDTH-1:0] o_out_data, // Head word
  input wire logic i_out_ready // Drain takes head
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  logic [AW-1:0] rd_nxt;
  logic [AW:0] cnt_d;
  // Handshakes, next head address and next fill count
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign rd_nxt = pop ? rd_q + 1'b1 : rd_q;
  assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  // Storage and pointers; ready comes from the next count so the port
  // leaves a flop without losing a cycle of throughput
  always_ff @(posedge i_sys_clk) begin
    if (push) mem_q[wr_q] <= i_in_data;
    if (i_reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      o_in_ready <= 1'b1;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      rd_q <= rd_nxt;
      cnt_q <= cnt_d;
      o_in_ready <= (cnt_d != DEPTH[AW:0]);
    end
  end
  // Head register; valid lags a write into an empty buffer by one cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_out_valid <= 1'b0;
      o_out_data <= '0;
    end else begin
      o_out_data <= mem_q[rd_nxt];
      o_out_valid <= (cnt_q - {{AW{1'b0}}, pop}) != '0;
    end
  end
endmodule : afc_fifo
`default_nettype wire

// [design/afc_host.sv]
// Purpose: Controller driving the strobes of an external 2048x9 FIFO.
// Assumes: Pins are asynchronous; flags pass three flip-flops.
// Notes: Writes are staged in an 8-word FIFO; reads are one word each.
// Notes on behaviour
// - Width grows in nine-bit steps
// - Chained flags are OR-combined
// - Token input grounded through clear selects single
// - First chained device grounds lead input
// - Later chained devices hold lead high
// - Token out feeds next token in; the host holds its token in pin low in every mode, chain mode included
// - Width mode shares controls, never outputs
// - Writer toggles strobe while not full
// - Watch full on written, empty on read
`timescale 1ns/10ps
`default_nettype none
`include "afc_cfg.svh"
module afc_host #(
  parameter int WIDTH = `AFC_WIDTH,
  parameter bit CHAIN_LEAD = 1'b1
) (
  input wire logic i_sys_clk, // System clock, 40 MHz
  input wire logic i_reset, // Synchronous reset, high
  input wire logic i_wr_valid, // Word to write offered
  input wire afc_pkg::afc_word_t i_wr_data, // Word to write
  output logic o_wr_ready, // Staging FIFO has room
  input wire logic i_rd_req, // Pulse: read one word
  output logic o_rd_valid, // Pulse: read word present
  output afc_pkg::afc_word_t o_rd_data, // Word read
  input wire logic i_clear_req, // Pulse: run master clear
  input wire logic i_replay_req, // Pulse: run replay
  input wire logic i_chain_mode, // High: depth chain setup
  output logic o_busy, // Cycle under way
  output logic o_full, // Synced full, high active
  output logic o_empty, // Synced empty, high active
  output logic o_half, // Synced half level, high
  output logic o_write_n, // Write strobe pin
  output logic o_read_n, // Read strobe pin
  output logic o_master_clear_n, // Master clear pin
  output logic o_lead_or_replay_n, // Lead or replay pin
  output logic o_chain_token_in_n, // Token pin in single mode
  output afc_pkg::afc_word_t o_dq_out, // Data to device
  input wire afc_pkg::afc_word_t i_dq_in, // Data from device
  input wire logic i_full_flag_n, // Device full flag
  input wire logic i_empty_flag_n, // Device empty flag
  input wire logic i_half_level_flag_n // Device half flag
);
  import afc_pkg::*;
  afc_state_t state_q, state_d;
  logic [`AFC_CNT_W-1:0] cnt_q, cnt_d;
  logic [2:0] ff_s_q, ef_s_q, hf_s_q;
  logic full_q, empty_q, half_q;
  logic clear_done_q;
  logic q_valid;
  afc_word_t q_data;
  logic q_pop;
  logic cnt_zero;
  logic go_clear, go_replay, go_write, go_read;
  logic chain_q;
  logic rd_done;

  // Staging buffer; the ready drops and stalls the source once 8 words wait
  afc_fifo #(.WIDTH(WIDTH), .DEPTH(`AFC_FIFO_DEPTH)) u_stage (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_in_valid(i_wr_valid),
    .i_in_data(i_wr_data),
    .o_in_ready(o_wr_ready),
    .o_out_valid(q_valid),
    .o_out_data(q_data),
    .i_out_ready(q_pop)
  );

  // Flag pins: a change counts once stages two and three agree
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ff_s_q <= 3'h7;
      ef_s_q <= 3'h0;
      hf_s_q <= 3'h7;
      full_q <= 1'b0;
      empty_q <= 1'b1;
      half_q <= 1'b0;
    end else begin
      ff_s_q <= {ff_s_q[1:0], i_full_flag_n};
      ef_s_q <= {ef_s_q[1:0], i_empty_flag_n};
      hf_s_q <= {hf_s_q[1:0], i_half_level_flag_n};
      if (ff_s_q[2] == ff_s_q[1]) full_q <= ~ff_s_q[2];
      if (ef_s_q[2] == ef_s_q[1]) empty_q <= ~ef_s_q[2];
      if (hf_s_q[2] == hf_s_q[1]) half_q <= ~hf_s_q[2];
    end
  end

  // Request decode in priority order: clear, replay, write, read
  assign cnt_zero = (cnt_q == '0);
  assign go_clear = i_clear_req || !clear_done_q;
  assign go_replay = i_replay_req && !chain_q;
  assign go_write = q_valid && !full_q;
  assign go_read = i_rd_req && !empty_q;
  assign q_pop = (state_q == AFC_IDLE) && !go_clear && !go_replay
                 && go_write;
  // Last low cycle of a read pulse; the bus is still driven here
  assign rd_done = (state_q == AFC_RSTRB) && cnt_zero;

  // Sequencer for one strobe cycle: pulse, then recovery
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_zero ? cnt_q : cnt_q - 1'b1;
    case (state_q)
      AFC_IDLE: begin
        if (go_clear) begin
          state_d = AFC_CLEAR;
          cnt_d = `AFC_CNT_W'(`AFC_PULSE_CYC);
        end else if (go_replay) begin
          state_d = AFC_REPLAY;
          cnt_d = `AFC_CNT_W'(`AFC_PULSE_CYC);
        end else if (go_write) begin
          state_d = AFC_WSTRB;
          cnt_d = `AFC_CNT_W'(`AFC_PULSE_CYC);
        end else if (go_read) begin
          state_d = AFC_RSTRB;
          cnt_d = `AFC_CNT_W'(`AFC_ACCESS_CYC);
        end
      end
      AFC_CLEAR, AFC_REPLAY, AFC_WSTRB, AFC_RSTRB: begin
        if (cnt_zero) begin
          state_d = AFC_RECOV;
          // Flags must settle before they are trusted again
          cnt_d = `AFC_CNT_W'(`AFC_FLAG_CYC + `AFC_SYNC_CYC);
        end
      end
      AFC_RECOV: begin
        if (cnt_zero) state_d = AFC_IDLE;
      end
      default: begin
        state_d = AFC_IDLE;
        cnt_d = '0;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_q <= AFC_IDLE;
      cnt_q <= '0;
      clear_done_q <= 1'b0;
      chain_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (state_q == AFC_CLEAR) clear_done_q <= 1'b1;
      if (state_q == AFC_IDLE) chain_q <= i_chain_mode;
    end
  end

  // Pin drivers; strobes are low only inside their pulse phase
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_write_n <= 1'b1;
      o_read_n <= 1'b1;
      o_master_clear_n <= 1'b1;
      o_lead_or_replay_n <= 1'b1;
      o_chain_token_in_n <= 1'b0;
      o_dq_out <= '0;
      o_rd_valid <= 1'b0;
      o_rd_data <= '0;
      o_busy <= 1'b0;
      o_full <= 1'b0;
      o_empty <= 1'b1;
      o_half <= 1'b0;
    end else begin
      o_write_n <= !(state_d == AFC_WSTRB);
      o_read_n <= !(state_d == AFC_RSTRB);
      o_master_clear_n <= !(state_d == AFC_CLEAR);
      // Lead level held through clear in a chain; replay pulse otherwise
      o_lead_or_replay_n <= chain_q ? !CHAIN_LEAD
                            : !(state_d == AFC_REPLAY);
      o_chain_token_in_n <= 1'b0;
      if (q_pop) o_dq_out <= q_data;
      o_rd_valid <= rd_done;
      if (rd_done) o_rd_data <= i_dq_in;
      o_busy <= (state_d != AFC_IDLE);
      o_full <= full_q;
      o_empty <= empty_q;
      o_half <= half_q && !chain_q;
    end
  end
endmodule : afc_host
`default_nettype wire

// [design/afc_pkg.sv]
// Purpose: Types shared by the external FIFO controller.
// Assumes: One-hot state codes.
// Notes: Constants live in afc_cfg.svh.
package afc_pkg;
  typedef enum logic [5:0] {
    AFC_IDLE = 6'h01,
    AFC_CLEAR = 6'h02,
    AFC_WSTRB = 6'h04,
    AFC_RSTRB = 6'h08,
    AFC_REPLAY = 6'h10,
    AFC_RECOV = 6'h20
  } afc_state_t;
  typedef logic [8:0] afc_word_t;
endpackage : afc_pkg

// [test/afc_dev_model.sv]
// Purpose: Behavioural stand-in for the 2048x9 FIFO part.
// Assumes: Single device mode.
// Notes: A released bus shows the inverse of the last word.
`timescale 1ns/10ps
`default_nettype none
module afc_dev_model (
  input wire logic i_write_n, // Write pin
  input wire logic i_read_n, // Read pin
  input wire logic i_master_clear_n, // Clear pin
  input wire logic i_lead_or_replay_n, // Replay pin
  input wire logic i_chain_token_in_n, // Token in
  input wire afc_pkg::afc_word_t i_dq, // Data in
  output afc_pkg::afc_word_t o_dq, // Data out
  output logic o_full_flag_n, // Full
  output logic o_empty_flag_n, // Empty
  output logic o_half_level_flag_n // Half
);
  import afc_pkg::*;
  afc_word_t mem [0:2047];
  afc_word_t last = 9'h000;
  logic [10:0] wp = 11'h000, rp = 11'h000;
  int cnt = 0;
  bit rd_ok = 0, wr_ok = 0;
  // Clear zeroes both pointers; replay rewinds only the read side
  always @(negedge i_master_clear_n or negedge i_lead_or_replay_n) begin
    if (!i_master_clear_n) begin
      wp = 11'h000;
      rp = 11'h000;
      cnt = 0;
    end else if (!i_chain_token_in_n) begin
      rp = 11'h000;
      cnt = wp;
    end
  end
  // Cycles start only while the governing flag is inactive
  always @(negedge i_write_n) wr_ok = cnt < 2048;
  always @(negedge i_read_n) rd_ok = cnt > 0;
  always @(posedge i_write_n) begin
    if (wr_ok && i_master_clear_n) begin
      mem[wp] = i_dq;
      wp++;
      cnt++;
    end
    wr_ok = 0;
  end
  always @(posedge i_read_n) begin
    if (rd_ok) begin
      last = mem[rp];
      rp++;
      cnt--;
    end
    rd_ok = 0;
  end
  // Flags are level decodes of the fill count
  assign o_dq = (!i_read_n && rd_ok) ? mem[rp] : ~last;
  assign o_full_flag_n = cnt != 2048;
  assign o_empty_flag_n = cnt != 0;
  assign o_half_level_flag_n = !(cnt > 1024);
endmodule : afc_dev_model
`default_nettype wire

// [test/afc_host_checker.sv]
// Purpose: Port assertions for the external FIFO controller.
// Assumes: One clock; chain mode only while the strobes rest.
// Notes: Flag checks allow for three sync flops.
`timescale 1ns/10ps
`default_nettype none
module afc_host_checker (
  input wire logic i_sys_clk, // Clock
  input wire logic i_reset, // Reset
  input wire logic o_busy, // Busy
  input wire logic o_full, // Full
  input wire logic o_empty, // Empty
  input wire logic o_rd_valid, // Word read
  input wire logic o_write_n, // Write pin
  input wire logic o_read_n, // Read pin
  input wire logic o_master_clear_n, // Clear pin
  input wire logic o_lead_or_replay_n, // Replay pin
  input wire logic o_chain_token_in_n, // Token pin
  input wire logic i_full_flag_n, // Part full
  input wire logic i_empty_flag_n // Part empty
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // Gating and widths of the strobes
  AST_WR_GATE: assert property ($fell(o_write_n) |-> !$past(o_full))
    else $error("write while full");
  AST_RD_GATE: assert property ($fell(o_read_n) |-> !$past(o_empty))
    else $error("read while empty");
  AST_WR_WIDTH: assert property ($fell(o_write_n) |->
    (!o_write_n)[*5] ##1 o_write_n) else $error("write width");
  AST_RD_WIDTH: assert property ($fell(o_read_n) |->
    (!o_read_n)[*5] ##1 o_read_n) else $error("read width");
  AST_RD_DATA: assert property ($fell(o_read_n) |-> ##[4:6] o_rd_valid)
    else $error("no read word");
  AST_BUSY: assert property (!o_write_n || !o_read_n |-> o_busy)
    else $error("strobe while idle");
  // Clear and replay only with both strobes quiet
  AST_CLR_QUIET: assert property (!o_master_clear_n |-> o_write_n && o_read_n)
    else $error("strobe in clear");
  AST_RPL_QUIET: assert property (o_master_clear_n && !o_lead_or_replay_n
    |-> o_write_n && o_read_n) else $error("strobe in replay");
  AST_BOOT_CLR: assert property ($fell(i_reset) |-> ##[1:4] !o_master_clear_n)
    else $error("no clear after reset");
  AST_TOKEN: assert property (o_chain_token_in_n == 1'b0)
    else $error("token pin high");
  AST_FULL_SYNC: assert property ((!i_full_flag_n)[*6] |-> o_full)
    else $error("full not seen");
  AST_EMPTY_SYNC: assert property ((!i_empty_flag_n)[*6] |-> o_empty)
    else $error("empty not seen");
endmodule : afc_host_checker
bind afc_host afc_host_checker u_chk (.i_sys_clk, .i_reset, .o_busy, .o_full,
  .o_empty, .o_rd_valid, .o_write_n, .o_read_n, .o_master_clear_n,
  .o_lead_or_replay_n, .o_chain_token_in_n, .i_full_flag_n, .i_empty_flag_n);
`default_nettype wire

// [test/afc_host_tb.sv]
// Purpose: Self-checking bench for the external FIFO controller.
// Assumes: Device model stands in for the part.
// Notes: The fill overruns the part and fills the 8-word staging FIFO so that it refuses.
`timescale 1ns/10ps
`default_nettype none
module afc_host_tb;
  import afc_pkg::*;
  logic clk = 0, rst = 1, wv = 0, rq = 0, clr = 0, rpl = 0, chn = 0;
  afc_word_t wd = 9'h000, rdd, dqo, dqi;
  logic wrdy, rdv, busy, full, empty, half, wn, rn, mcn, lrn, tin;
  logic ffn, efn, hfn;
  int err_total = 0, cmp_count = 0;
  always #12.5 clk = ~clk;
  afc_host uut (.i_sys_clk(clk), .i_reset(rst), .i_wr_valid(wv),
    .i_wr_data(wd), .o_wr_ready(wrdy), .i_rd_req(rq), .o_rd_valid(rdv),
    .o_rd_data(rdd), .i_clear_req(clr), .i_replay_req(rpl),
    .i_chain_mode(chn), .o_busy(busy), .o_full(full), .o_empty(empty),
    .o_half(half), .o_write_n(wn), .o_read_n(rn), .o_master_clear_n(mcn),
    .o_lead_or_replay_n(lrn), .o_chain_token_in_n(tin), .o_dq_out(dqo),
    .i_dq_in(dqi), .i_full_flag_n(ffn), .i_empty_flag_n(efn),
    .i_half_level_flag_n(hfn));
  afc_dev_model u_dev (.i_write_n(wn), .i_read_n(rn),
    .i_master_clear_n(mcn), .i_lead_or_replay_n(lrn),
    .i_chain_token_in_n(tin), .i_dq(dqo), .o_dq(dqi),
    .o_full_flag_n(ffn), .o_empty_flag_n(efn), .o_half_level_flag_n(hfn));
  task chk(input logic [8:0] s, input logic [8:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("mismatch at %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task print_verdict;
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  // Bounded wait: 0 idle, 1 ready, 2 read word, 3 busy
  task automatic wt(input int k);
    int n;
    for (n = 0; n < 600; n++) begin
      if (k == 0 ? busy === 1'b0 : k == 1 ? wrdy === 1'b1 :
          k == 2 ? rdv === 1'b1 : busy === 1'b1) break;
      @(negedge clk);
    end
    if (n == 600) begin
      err_total++;
      print_verdict;
    end
  endtask : wt
  // A clock edge passes after each drop so no pin is set twice at once
  task push(input afc_word_t w);
    wd = w;
    wv = 1;
    wt(1);
    @(negedge clk);
    wv = 0;
    @(negedge clk);
  endtask : push
  task rd(input afc_word_t e);
    rq = 1;
    wt(2);
    chk(rdd, e);
    rq = 0;
    @(negedge clk);
  endtask : rd
  task ctl(input logic c);
    wt(0);
    clr = c;
    rpl = !c;
    wt(3);
    clr = 0;
    rpl = 0;
    wt(0);
  endtask : ctl
  task t_replay;
    chk(empty, 1'b1);
    push(9'h1A5);
    push(9'h05A);
    rd(9'h1A5);
    ctl(1'b0);
    chk(empty, 1'b0);
    rd(9'h1A5);
    rd(9'h05A);
    wt(0);
    chk(empty, 1'b1);
  endtask : t_replay
  task automatic t_fill;
    int i;
    ctl(1'b1);
    chk(full, 1'b0);
    chk(empty, 1'b1);
    for (i = 0; i < 2056; i++) push(i[8:0] ^ 9'h0A5);
    wt(0);
    chk(full, 1'b1);
    chk(half, 1'b1);
    chk(wrdy, 1'b0);
    for (i = 0; i < 2056; i++) rd(i[8:0] ^ 9'h0A5);
    wt(0);
    chk(half, 1'b0);
    chk(empty, 1'b1);
  endtask : t_fill
  // Depth chain: lead pin held low, replay refused, half forced off
  task t_chain;
    ctl(1'b1);
    chn = 1;
    repeat (3) @(negedge clk);
    chk(lrn, 1'b0);
    rpl = 1;
    repeat (4) @(negedge clk);
    chk(busy, 1'b0);
    chk(half, 1'b0);
    ctl(1'b1);
    chk(empty, 1'b1);
    chk(lrn, 1'b0);
    chn = 0;
    repeat (3) @(negedge clk);
    chk(lrn, 1'b1);
  endtask : t_chain
  initial begin
    repeat (8) @(negedge clk);
    rst = 0;
    wt(3);
    wt(0);
    t_replay;
    t_fill;
    t_chain;
    print_verdict;
  end
endmodule : afc_host_tb
`default_nettype wire
